// file: hdl/host_serial_port_pin_select.sv
// Behaviour
// - Strap high selects the two-wire bus, strap low selects SPI.
// - Two-wire mode: shared data pin is open-drain, only ever pulled low.
// - Three-wire SPI: data pin bidirectional; four-wire SPI: data pin input only.
// - In SPI mode the data pin is driven push-pull when it outputs.
// - Two-wire mode: address-one pin is an undriven input giving address bit A1.
// - Four-wire SPI: address-one pin drives read data push-pull to the host.
// - Serial clock pin is input only in both modes; host drives it.
// - Two-wire mode: address-zero pin supplies strapped address bit A0.
// - SPI: host selects with chip select low; transfers only honoured while low.
// - Alert output goes low when any device status has changed.
// - Reset low performs a full reset of all internal logic.
// - Reset loads every register with its default, discarding configuration.
// - Clock outputs stay disabled while reset is in progress.
// - Output signal format comes from a host-programmed register.
`timescale 1ns/1ps
`default_nettype none

module host_serial_port_pin_select #(
   parameter int NUM_OUTPUTS = 4,
   parameter int FORMAT_W    = 3,
   parameter int STATUS_W    = 8
) (
   // Clock and reset.
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // Strap and serial pins from the host side.
   input  wire logic                          interfaceSelectPin,
   input  wire logic                          serialClockPin,
   input  wire logic                          addressZeroOrChipSelectPin,
   input  wire logic                          dataPinIn,
   output logic                               dataPinOut,
   output logic                               dataPinOe,
   input  wire logic                          addressOneOrDataOutPinIn,
   output logic                               addressOneOrDataOutPinOut,
   output logic                               addressOneOrDataOutPinOe,
   output logic                               status_change_alert_n,
   // Serial engine side.
   output logic                               i2cMode,
   output logic [1:0]                         slaveAddressBits,
   output logic                               spiSelected,
   output logic                               serialClockRise,
   output logic                               serialClockFall,
   output logic                               serialDataIn,
   input  wire logic                          coreDataOut,
   input  wire logic                          coreDataOe,
   // Configuration written by the serial engine, and the clock output enable.
   input  wire logic                          cfgWrite,
   input  wire logic [NUM_OUTPUTS*FORMAT_W:0] cfgData,
   output logic                               threeWireSpi,
   output logic [NUM_OUTPUTS*FORMAT_W-1:0]    outputFormat,
   output logic                               clockOutputsEnable,
   // Device status and alert acknowledge.
   input  wire logic [STATUS_W-1:0]           statusIn,
   input  wire logic                          alertClear
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   logic [4:0] pinMeta_r;
   logic [4:0] pinSync_r;
   logic       sclkPrev_r;
   logic       selSync;
   logic       sclkSync;
   logic       csSync;
   logic       dataSync;
   logic       a1Sync;

   // Every pin is asynchronous to clk, so each passes two flops first.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta_r <= 5'h0_0;
         pinSync_r <= 5'h0_0;
      end else begin
         pinMeta_r <= {interfaceSelectPin, serialClockPin, addressZeroOrChipSelectPin,
                       dataPinIn, addressOneOrDataOutPinIn};
         pinSync_r <= pinMeta_r;
      end
   end

   assign selSync  = pinSync_r[4];
   assign sclkSync = pinSync_r[3];
   assign csSync   = pinSync_r[2];
   assign dataSync = pinSync_r[1];
   assign a1Sync   = pinSync_r[0];

   // ****************************************************************
   // Reset sequence and strap capture
   // ****************************************************************

   host_serial_port_pin_select_pkg::state_t state_r;
   host_serial_port_pin_select_pkg::state_t state_nxt;
   logic [1:0] settleCount_r;
   logic       settleDone;
   logic       running;

   assign settleDone = (settleCount_r == host_serial_port_pin_select_pkg::SETTLE_COUNT_LAST);
   assign running    = (state_r == host_serial_port_pin_select_pkg::ST_RUN);

   // Next state: wait out the synchronisers before trusting the straps.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         host_serial_port_pin_select_pkg::ST_RESET: begin
            state_nxt = host_serial_port_pin_select_pkg::ST_SETTLE;
         end
         host_serial_port_pin_select_pkg::ST_SETTLE: begin
            if (settleDone) begin
               state_nxt = host_serial_port_pin_select_pkg::ST_RUN;
            end
         end
         host_serial_port_pin_select_pkg::ST_RUN: begin
            state_nxt = host_serial_port_pin_select_pkg::ST_RUN;
         end
         default: begin
            state_nxt = host_serial_port_pin_select_pkg::ST_RESET;
         end
      endcase
   end

   // Asynchronous reset returns the whole sequence to its start.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r       <= host_serial_port_pin_select_pkg::ST_RESET;
         settleCount_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         if (state_r == host_serial_port_pin_select_pkg::ST_SETTLE && !settleDone) begin
            settleCount_r <= settleCount_r + 2'h1;
         end
      end
   end

   // Straps are caught once, on the settle-to-run step, so a pin that
   // wiggles later cannot change the mode or address mid-operation.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         i2cMode          <= host_serial_port_pin_select_pkg::MODE_I2C_LEVEL;
         slaveAddressBits <= 2'h0;
      end else if (state_r == host_serial_port_pin_select_pkg::ST_SETTLE && settleDone) begin
         i2cMode          <= (selSync == host_serial_port_pin_select_pkg::MODE_I2C_LEVEL);
         slaveAddressBits <= {a1Sync, csSync};
      end
   end

   // ****************************************************************
   // Serial clock sampling and chip select gating
   // ****************************************************************

   logic csActive;
   logic linkOpen;

   // The serial clock is only ever sampled; no output exists for it.
   assign csActive = running && !i2cMode && !csSync;
   assign linkOpen = running && (i2cMode || !csSync);

   // Edge pulses reach the engine only while the link is open.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclkPrev_r      <= 1'b0;
         serialClockRise <= 1'b0;
         serialClockFall <= 1'b0;
         spiSelected     <= 1'b0;
         serialDataIn    <= 1'b0;
      end else begin
         sclkPrev_r      <= sclkSync;
         serialClockRise <= linkOpen && sclkSync && !sclkPrev_r;
         serialClockFall <= linkOpen && !sclkSync && sclkPrev_r;
         spiSelected     <= csActive;
         serialDataIn    <= dataSync;
      end
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************

   // Two-wire mode only ever pulls low; SPI drives both levels.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dataPinOut                <= 1'b0;
         dataPinOe                 <= 1'b0;
         addressOneOrDataOutPinOut <= 1'b0;
         addressOneOrDataOutPinOe  <= 1'b0;
      end else if (running && i2cMode) begin
         dataPinOut                <= 1'b0;
         dataPinOe                 <= coreDataOe;
         addressOneOrDataOutPinOut <= 1'b0;
         addressOneOrDataOutPinOe  <= 1'b0;
      end else begin
         dataPinOut                <= coreDataOut;
         dataPinOe                 <= csActive && threeWireSpi && coreDataOe;
         addressOneOrDataOutPinOut <= coreDataOut;
         addressOneOrDataOutPinOe  <= csActive && !threeWireSpi;
      end
   end

   // ****************************************************************
   // Configuration and clock output enable
   // ****************************************************************

   // Reset discards any format the host wrote; writes count only in run.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         outputFormat <= {NUM_OUTPUTS{host_serial_port_pin_select_pkg::FORMAT_RESET_VALUE}};
         threeWireSpi <= 1'b0;
      end else if (running && cfgWrite) begin
         outputFormat <= cfgData[NUM_OUTPUTS*FORMAT_W-1:0];
         threeWireSpi <= cfgData[NUM_OUTPUTS*FORMAT_W];
      end
   end

   // Outputs stay off until the reset sequence has reached run.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clockOutputsEnable <= 1'b0;
      end else begin
         clockOutputsEnable <= (state_nxt == host_serial_port_pin_select_pkg::ST_RUN);
      end
   end

   // ****************************************************************
   // Status change alert
   // ****************************************************************

   logic [STATUS_W-1:0] statusPrev_r;
   logic                statusChanged;

   assign statusChanged = running && (statusIn != statusPrev_r);

   // A change in the same cycle as the clear wins, so no event is lost.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         statusPrev_r          <= '0;
         status_change_alert_n <= 1'b1;
      end else begin
         statusPrev_r <= statusIn;
         if (statusChanged) begin
            status_change_alert_n <= 1'b0;
         end else if (alertClear) begin
            status_change_alert_n <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   AST_MODE_FROM_STRAP: assert property (
      (state_r == host_serial_port_pin_select_pkg::ST_SETTLE && settleDone)
      |=> (i2cMode == ($past(selSync) == host_serial_port_pin_select_pkg::MODE_I2C_LEVEL))
          && (slaveAddressBits == $past({a1Sync, csSync})))
      else $error("Mode or address not taken from straps at release.");
   AST_STRAP_HELD: assert property (
      running && $past(running) |-> $stable(i2cMode) && $stable(slaveAddressBits))
      else $error("Strap values changed while running.");
   AST_I2C_OPEN_DRAIN: assert property (
      $past(running && i2cMode) && dataPinOe |-> !dataPinOut)
      else $error("Data pin driven high in two-wire mode.");
   AST_FOUR_WIRE_INPUT: assert property (
      !i2cMode && !threeWireSpi |=> !dataPinOe)
      else $error("Data pin driven in four-wire SPI mode.");
   AST_SPI_PUSH_PULL: assert property (
      csActive && threeWireSpi && coreDataOe
      |=> dataPinOe && (dataPinOut == $past(coreDataOut)))
      else $error("Three-wire SPI data not driven push-pull.");
   AST_A1_UNDRIVEN: assert property (
      running && i2cMode |=> !addressOneOrDataOutPinOe)
      else $error("Address-one pin driven in two-wire mode.");
   AST_SDO_DRIVE: assert property (
      csActive && !threeWireSpi |=> addressOneOrDataOutPinOe
          && (addressOneOrDataOutPinOut == $past(coreDataOut)))
      else $error("Four-wire SPI read data not driven.");
   AST_CS_GATES_CLOCK: assert property (
      serialClockRise || serialClockFall |-> $past(running && (i2cMode || !csSync)))
      else $error("Serial clock edge passed while not selected.");
   AST_ALERT_SET: assert property (
      statusChanged |=> !status_change_alert_n ##1 (!status_change_alert_n || $past(alertClear)))
      else $error("Status change did not pull the alert low.");
   AST_CLOCKS_OFF: assert property (
      !running |-> !clockOutputsEnable)
      else $error("Clock outputs enabled before reset sequence ended.");
   AST_FORMAT_DEFAULT: assert property (
      state_r == host_serial_port_pin_select_pkg::ST_SETTLE
      |-> outputFormat == {NUM_OUTPUTS{host_serial_port_pin_select_pkg::FORMAT_RESET_VALUE}}
          && !threeWireSpi)
      else $error("Output format not at its default after reset.");
   AST_FORMAT_WRITE: assert property (
      running && cfgWrite |=> outputFormat == $past(cfgData[NUM_OUTPUTS*FORMAT_W-1:0]))
      else $error("Output format write not applied.");

   COV_I2C_RUN: cover property (running && i2cMode && dataPinOe);
   COV_SPI_THREE_WIRE: cover property (csActive && threeWireSpi ##1 dataPinOe);
   COV_SPI_FOUR_WIRE: cover property (csActive && !threeWireSpi ##1 addressOneOrDataOutPinOe);
   COV_ALERT_CLEARED: cover property (!status_change_alert_n ##1 status_change_alert_n);

endmodule

`default_nettype wire

// file: hdl/host_serial_port_pin_select_pkg.sv
`default_nettype none
package host_serial_port_pin_select_pkg;

   // ****************************************************************
   // Strap encodings and reset values
   // ****************************************************************

   // Interface-select strap level that picks the two-wire bus.
   localparam logic       MODE_I2C_LEVEL     = 1'b1;
   // Format code every clock output takes after reset.
   localparam logic [2:0] FORMAT_RESET_VALUE = 3'h0;
   // Cycles after reset release before straps are trusted; covers the
   // two synchroniser stages plus one spare cycle.
   localparam int         STRAP_SETTLE_CYCLES = 3;
   localparam logic [1:0] SETTLE_COUNT_LAST   = 2'(STRAP_SETTLE_CYCLES - 1);

   // ****************************************************************
   // Control sequence, Gray coded along reset, settle, run
   // ****************************************************************

   typedef enum logic [1:0] {
      ST_RESET  = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN    = 2'b11
   } state_t;

endpackage
`default_nettype wire

// file: bench/host_serial_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host controller at the far end of the serial pins
// ****************************************************************
module host_serial_master_model (
   // Clock and strap levels.
   input  wire logic clk,
   input  wire logic i2cStrap,
   input  wire logic a1Strap,
   // Device pin drives.
   input  wire logic dataOe,
   input  wire logic dataOut,
   input  wire logic a1Oe,
   input  wire logic a1Out,
   // Resolved pin levels.
   output logic      sck,
   output var logic  csPin,
   output logic      dataWire,
   output logic      a1Wire
);
   logic inFrame;
   logic sckFrame;
   logic noise;

   // Clock idles at its bus level outside frames, high under the pull-up.
   assign sck = inFrame ? sckFrame : i2cStrap;
   // Undriven data floats; without a pull-up it toggles so no stale value reads true.
   assign dataWire = dataOe ? dataOut : (i2cStrap ? 1'b1 : noise);
   assign a1Wire = a1Oe ? a1Out : a1Strap;

   // Pattern source for the floating line.
   always @(posedge clk) begin
      noise <= ~noise;
   end

   initial begin
      inFrame = 1'b0;
      sckFrame = 1'b0;
      noise = 1'b0;
      csPin = 1'b1;
   end

   // Chip select, low selects the device.
   task automatic sel(input logic lvl);
      csPin = lvl;
   endtask

   // One frame of serial clocks at 125 ns per bit.
   task automatic frame(input int bits);
      sckFrame = i2cStrap;
      inFrame = 1'b1;
      repeat (bits) begin
         #62.5 sckFrame = ~i2cStrap;
         #62.5 sckFrame = i2cStrap;
      end
      #62.5 inFrame = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: bench/host_serial_port_pin_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_pin_select_tb;
   logic clk, reset_n, strap, a1Strap, sck, csPin, dataWire, a1Wire;
   logic dOut, dOe, a1Out, a1Oe, alert_n, i2cMode, spiSel, rise, fall, sdi;
   logic coreOut, coreOe, cfgWrite, threeWire, clkEn, alertClear;
   logic [1:0] addr;
   logic [12:0] cfgData;
   logic [11:0] fmt;
   logic [7:0] statusIn;
   int failures, n_checks, rises, falls;

   host_serial_port_pin_select dut (.clk(clk), .reset_n(reset_n),
      .interfaceSelectPin(strap), .serialClockPin(sck),
      .addressZeroOrChipSelectPin(csPin), .dataPinIn(dataWire), .dataPinOut(dOut),
      .dataPinOe(dOe), .addressOneOrDataOutPinIn(a1Wire),
      .addressOneOrDataOutPinOut(a1Out), .addressOneOrDataOutPinOe(a1Oe),
      .status_change_alert_n(alert_n), .i2cMode(i2cMode), .slaveAddressBits(addr),
      .spiSelected(spiSel), .serialClockRise(rise), .serialClockFall(fall),
      .serialDataIn(sdi), .coreDataOut(coreOut), .coreDataOe(coreOe),
      .cfgWrite(cfgWrite), .cfgData(cfgData), .threeWireSpi(threeWire),
      .outputFormat(fmt), .clockOutputsEnable(clkEn), .statusIn(statusIn),
      .alertClear(alertClear));

   host_serial_master_model host (.clk(clk), .i2cStrap(strap), .a1Strap(a1Strap),
      .dataOe(dOe), .dataOut(dOut), .a1Oe(a1Oe), .a1Out(a1Out), .sck(sck),
      .csPin(csPin), .dataWire(dataWire), .a1Wire(a1Wire));

   // ****************************************************************
   // Clock, edge counters and shared helpers
   // ****************************************************************

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Pulses last one cycle, so they are counted at every rising clock edge.
   always @(posedge clk) begin
      if (rise === 1'b1) rises++;
      if (fall === 1'b1) falls++;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Reset with given straps; defaults are judged while it is held.
   task automatic do_reset(input logic i2c, input logic a0, input logic a1);
      strap = i2c;
      a1Strap = a1;
      host.sel(a0);
      reset_n = 1'b0;
      cyc(20);
      chk(16'({dOe, a1Oe, alert_n, clkEn, threeWire, i2cMode, addr, spiSel}), 16'h0048);
      chk(16'(fmt), 16'({4{host_serial_port_pin_select_pkg::FORMAT_RESET_VALUE}}));
      reset_n = 1'b1;
      // Outputs must stay off while the straps are still settling.
      cyc(2);
      chk(16'(clkEn), 16'h0000);
      cyc(4);
      chk(16'(clkEn), 16'h0001);
   endtask

   task automatic write_cfg(input logic [12:0] d);
      cfgData = d;
      cfgWrite = 1'b1;
      cyc(1);
      cfgWrite = 1'b0;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************

   // Two-wire mode: straps, open-drain data, address pin never driven.
   task automatic t_i2c();
      do_reset(1'b1, 1'b1, 1'b0);
      chk(16'({i2cMode, addr}), 16'h0005);
      a1Strap = 1'b1;
      host.sel(1'b0);
      cyc(6);
      chk(16'(addr), 16'h0001);
      {coreOe, coreOut} = 2'b11;
      cyc(5);
      chk(16'({dOe, dOut, a1Oe, sdi}), 16'h0008);
      coreOe = 1'b0;
      rises = 0;
      falls = 0;
      host.frame(8);
      cyc(5);
      chk({rises[7:0], falls[7:0]}, 16'h0808);
      chk(16'(sdi), 16'h0001);
   endtask

   // SPI: chip select gating, four-wire then three-wire drives.
   task automatic t_spi();
      do_reset(1'b0, 1'b1, 1'b0);
      chk(16'(i2cMode), 16'h0000);
      rises = 0;
      falls = 0;
      host.frame(4);
      cyc(5);
      chk({rises[7:0], falls[7:0]}, 16'h0000);
      host.sel(1'b0);
      {coreOe, coreOut} = 2'b11;
      cyc(5);
      chk(16'({spiSel, dOe, a1Oe, a1Out}), 16'h000b);
      // Read data must follow the engine bit by bit, both levels.
      for (int i = 0; i < 4; i++) begin
         coreOut = i[0];
         cyc(2);
         chk(16'({a1Oe, a1Out}), 16'({1'b1, i[0]}));
      end
      host.frame(8);
      cyc(5);
      chk({rises[7:0], falls[7:0]}, 16'h0808);
      write_cfg(13'h1000);
      cyc(2);
      chk(16'({threeWire, dOe, dOut, a1Oe}), 16'h000e);
      coreOut = 1'b0;
      cyc(2);
      chk(16'({dOe, dOut}), 16'h0002);
      coreOe = 1'b0;
      cyc(2);
      chk(16'(dOe), 16'h0000);
      coreOe = 1'b1;
      host.sel(1'b1);
      cyc(5);
      chk(16'({spiSel, dOe, a1Oe}), 16'h0000);
      coreOe = 1'b0;
   endtask

   // Format registers, back-to-back writes, then lost on reset.
   task automatic t_cfg();
      cfgData = 13'h05a3;
      cfgWrite = 1'b1;
      cyc(1);
      chk(16'({threeWire, fmt}), 16'h05a3);
      // Strobe stays high so the second word follows on the next edge.
      cfgData = 13'h0c3f;
      cyc(1);
      cfgWrite = 1'b0;
      chk(16'({threeWire, fmt}), 16'h0c3f);
      do_reset(1'b1, 1'b0, 1'b1);
      chk(16'({i2cMode, addr}), 16'h0006);
   endtask

   // Alert sets on a status change, clears, and set beats clear.
   task automatic t_alert();
      statusIn = statusIn ^ 8'h01;
      cyc(3);
      chk(16'(alert_n), 16'h0000);
      alertClear = 1'b1;
      cyc(1);
      alertClear = 1'b0;
      cyc(2);
      chk(16'(alert_n), 16'h0001);
      statusIn = statusIn ^ 8'h80;
      alertClear = 1'b1;
      cyc(1);
      alertClear = 1'b0;
      cyc(2);
      chk(16'(alert_n), 16'h0000);
   endtask

   // Main sequence; every input starts from a known level.
   initial begin
      {reset_n, strap, a1Strap, coreOut, coreOe, cfgWrite, alertClear} = 7'h00;
      cfgData = 13'h0000;
      statusIn = 8'h00;
      failures = 0;
      n_checks = 0;
      cyc(1);
      t_i2c();
      t_spi();
      t_cfg();
      t_alert();
      end_of_test();
   end

   // Watchdog against a hung run.
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      end_of_test();
   end
endmodule
`default_nettype wire
